// ---- design/dcc_consts.vh ----
// Purpose: constants for the disk channel command port
// Assumes: 16-bit bus words, little-endian bit numbering on the bus
// Notes: register access is by function code, no separate address map
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH

// =====================================================================
// function codes
`define DCC_FC_ID 6'h00
`define DCC_FC_OCW 6'h01
`define DCC_FC_INTLVL 6'h02
`define DCC_FC_OINTLVL 6'h03
`define DCC_FC_TASK 6'h07
`define DCC_FC_MEMADR 6'h08
`define DCC_FC_OMEMADR 6'h09
`define DCC_FC_MODADR 6'h0a
`define DCC_FC_OMODADR 6'h0b
`define DCC_FC_RANGE 6'h0c
`define DCC_FC_ORANGE 6'h0d
`define DCC_FC_OFFS 6'h0e
`define DCC_FC_OOFFS 6'h0f
`define DCC_FC_CFGA 6'h10
`define DCC_FC_CFGB 6'h12
`define DCC_FC_CFGC 6'h14
`define DCC_FC_OCFGA 6'h11
`define DCC_FC_OCFGB 6'h13
`define DCC_FC_OCFGC 6'h15
`define DCC_FC_STAT1 6'h18
`define DCC_FC_IDCODE 6'h26

// =====================================================================
// control word bits, task op codes
`define DCC_OCW_INIT 0
`define DCC_OCW_STOP 1
`define DCC_OP_WRAPW 4'h1
`define DCC_OP_WRAPR 4'h2
`define DCC_OP_SPMDMP 4'h3

// =====================================================================
// sizes and fields
`define DCC_BUF_BYTES 16'h0100
`define DCC_SPM_BYTES 16'h0100
`define DCC_PERR_BIT 5
`define DCC_LVL_LSB 0
`define DCC_LVL_RST 6'h00
`define DCC_WORD_RST 16'h0000

`endif

// ---- design/dcc_byte_ram.v ----
// Purpose: byte storage indexed by address, flip-flop based
// Assumes: single write port, combinational read
// Notes: used for wraparound buffer and scratch pad
`timescale 1ns/1ns
`default_nettype none
module dcc_byte_ram (
  // clock
  input wire clk_i,
  // write side
  input wire we_i,
  input wire [7:0] waddr_i,
  input wire [7:0] wdata_i,
  // read side
  input wire [7:0] raddr_i,
  output wire [7:0] rdata_o
);
  reg [7:0] mem [0:255];
  // no reset: contents are data, not control
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
  assign rdata_o = mem[raddr_i];
endmodule
`default_nettype wire

// ---- design/dcc_mem_port.v ----
// Purpose: byte-wide main memory request port for one transfer
// Assumes: memory answers with ack; one request outstanding
// Notes: counts bytes down, one step pulse per acknowledged byte
`timescale 1ns/1ns
`default_nettype none
module dcc_mem_port (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // control
  input wire start_i,
  input wire abort_i,
  input wire [15:0] count_i,
  input wire ack_i,
  // status
  output reg busy_o,
  output reg step_o
);
  reg [15:0] left;
  // one step per acknowledged byte, abort drops at once
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      step_o <= 1'b0;
      left <= 16'h0000;
    end else begin
      step_o <= 1'b0;
      if (abort_i) begin
        busy_o <= 1'b0;
      end else if (start_i) begin
        busy_o <= 1'b1;
        left <= count_i;
      end else if (busy_o && ack_i) begin
        step_o <= 1'b1;
        left <= left - 16'h0001;
        if (left == 16'h0001) begin
          busy_o <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/dcc_cmd_port.v ----
// Purpose: command interpreter for one disk controller channel
// Assumes: bus request decoded to one-cycle strobe with function code
// Notes: answer in the cycle after the request, echo on address
`timescale 1ns/1ns
`default_nettype none
`include "dcc_consts.vh"
module dcc_cmd_port #(
  parameter [15:0] CTRL_ID = 16'h5a01, // arbitrary value
  parameter [9:0] CHAN_NUM = 10'h000
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // bus request
  input wire req_i,
  input wire [5:0] fc_i,
  input wire [15:0] data_i,
  input wire master_clear_i,
  // unit identification from attached drive
  input wire [15:0] unit_code_i,
  // main memory byte port
  input wire mem_ack_i,
  input wire [7:0] mem_rdata_i,
  output reg mem_req_o,
  output reg mem_we_o,
  output reg [23:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  // bus response
  output reg rsp_valid_o,
  output reg [15:0] rsp_data_o,
  output reg [15:0] rsp_addr_o,
  // events
  output reg irq_o,
  output reg recal_o,
  output reg busy_o
);

  // ===================================================================
  // state
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_WRAPW = 4'b0010;
  localparam [3:0] S_WRAPR = 4'b0100;
  localparam [3:0] S_DUMP = 4'b1000;

  reg [3:0] state;
  reg [15:0] byte_adr;
  reg [7:0] mod_adr;
  reg [15:0] range;
  reg [15:0] offs;
  reg [15:0] cfg_a;
  reg [15:0] cfg_b;
  reg [15:0] cfg_c;
  reg [5:0] lvl;
  reg [15:0] stat1;
  reg [15:0] task_word;
  reg wrap_armed;
  reg [7:0] idx;
  reg [15:0] xfer_len;

  // input codes decoded once
  // odd codes are outputs, even codes ask for an answer
  function is_input;
    input [5:0] fc;
    begin
      is_input = ~fc[0];
    end
  endfunction

  wire [7:0] rdata;
  wire mp_busy;
  // byte accepted by memory on this edge
  wire byte_done;
  wire start_xfer;
  wire ocw = req_i && (fc_i == `DCC_FC_OCW);
  wire do_init = master_clear_i ||
    (ocw && data_i[`DCC_OCW_INIT]);
  wire do_stop = ocw && data_i[`DCC_OCW_STOP] && !data_i[`DCC_OCW_INIT];
  wire task_req = req_i && (fc_i == `DCC_FC_TASK);
  wire [3:0] op = data_i[3:0];
  wire len_zero = (range == 16'h0000);
  wire len_big = (range > `DCC_BUF_BYTES);
  wire idle = (state == S_IDLE);
  // the byte is taken on the ack edge itself, while the read data stands;
  // the port's registered step pulse comes a cycle late, when memory may
  // already show stale data, and the address would move too late as well
  assign byte_done = !idle && mp_busy && mem_ack_i;

  // =================================================================
  // buffer and scratch storage
  // one store serves the wraparound buffer and the scratch dump
  dcc_byte_ram u_buf (
    .clk_i(clk_i),
    .we_i((state == S_WRAPW) && byte_done),
    .waddr_i(idx),
    .wdata_i(mem_rdata_i),
    .raddr_i(idx),
    .rdata_o(rdata)
  );

  assign start_xfer = task_req && idle &&
    ((op == `DCC_OP_SPMDMP) ||
     (((op == `DCC_OP_WRAPW) ||
       ((op == `DCC_OP_WRAPR) && wrap_armed)) &&
      !len_zero && !len_big));

  dcc_mem_port u_mp (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start_xfer),
    .abort_i(do_init || do_stop),
    .count_i((op == `DCC_OP_SPMDMP) ? `DCC_SPM_BYTES : range),
    .ack_i(mem_ack_i),
    .busy_o(mp_busy),
    // step pulse unused: progress follows the ack directly
    .step_o()
  );

  // =================================================================
  // command sequencing and registers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      byte_adr <= `DCC_WORD_RST;
      mod_adr <= 8'h00;
      range <= `DCC_WORD_RST;
      offs <= `DCC_WORD_RST;
      cfg_a <= `DCC_WORD_RST;
      cfg_b <= `DCC_WORD_RST;
      cfg_c <= `DCC_WORD_RST;
      lvl <= `DCC_LVL_RST;
      stat1 <= `DCC_WORD_RST;
      task_word <= `DCC_WORD_RST;
      wrap_armed <= 1'b0;
      idx <= 8'h00;
      xfer_len <= 16'h0000;
      irq_o <= 1'b0;
      recal_o <= 1'b0;
    end else begin
      irq_o <= 1'b0;
      recal_o <= 1'b0;
      if (do_init) begin
        // abort silently, level zero
        // every software-visible register back to its power-up value
        state <= S_IDLE;
        byte_adr <= `DCC_WORD_RST;
        mod_adr <= 8'h00;
        range <= `DCC_WORD_RST;
        offs <= `DCC_WORD_RST;
        cfg_a <= `DCC_WORD_RST;
        cfg_b <= `DCC_WORD_RST;
        cfg_c <= `DCC_WORD_RST;
        lvl <= `DCC_LVL_RST;
        stat1 <= `DCC_WORD_RST;
        task_word <= `DCC_WORD_RST;
        wrap_armed <= 1'b0;
        recal_o <= 1'b1;
      end else if (do_stop) begin
        // address, count, status kept
        // only state, wrap_armed and irq_o change, so the host can read back what the
        // transfer had reached when the stop arrived
        state <= S_IDLE;
        wrap_armed <= 1'b0;
        irq_o <= !idle && (lvl != 6'h00);
      end else begin
        // register loads, only when idle
        // loads while busy are dropped, the host must wait for the end
        if (req_i && idle) begin
          case (fc_i)
            `DCC_FC_OINTLVL: lvl <= data_i[5:0];
            `DCC_FC_OMEMADR: byte_adr <= data_i;
            `DCC_FC_OMODADR: mod_adr <= data_i[7:0];
            `DCC_FC_ORANGE: range <= data_i;
            `DCC_FC_OOFFS: offs <= data_i;
            `DCC_FC_OCFGA: cfg_a <= data_i;
            `DCC_FC_OCFGB: cfg_b <= data_i;
            `DCC_FC_OCFGC: cfg_c <= data_i;
            default: ;
          endcase
        end
        if (task_req && idle) begin
          task_word <= data_i;
          stat1[`DCC_PERR_BIT] <= 1'b0;
          idx <= 8'h00;
          xfer_len <= range;
          if (op == `DCC_OP_SPMDMP) begin
            state <= S_DUMP;
            wrap_armed <= 1'b0;
          end else if (op == `DCC_OP_WRAPW ||
                       op == `DCC_OP_WRAPR) begin
            if (len_zero) begin
              wrap_armed <= 1'b0;
            end else if (len_big) begin
              stat1[`DCC_PERR_BIT] <= 1'b1;
              wrap_armed <= 1'b0;
            end else if (op == `DCC_OP_WRAPW) begin
              state <= S_WRAPW;
              wrap_armed <= 1'b0;
            end else if (wrap_armed) begin
              state <= S_WRAPR;
              wrap_armed <= 1'b0;
            end
          end else begin
            wrap_armed <= 1'b0;
          end
        end
        // transfer progress: address steps, count falls except in the dump
        // stepping on the ack gives the next address time to reach the
        // memory port before memory can answer the following request
        if (byte_done) begin
          idx <= idx + 8'h01;
          byte_adr <= byte_adr + 16'h0001;
          if (state != S_DUMP) begin
            range <= range - 16'h0001;
          end
        end
        // end of transfer once the port has counted its last byte; the
        // write rewinds address and count so a read can follow directly
        if (!idle && !mp_busy && !start_xfer &&
            !(task_req && idle)) begin
          if (state == S_WRAPW) begin
            // arming only allows the read; it still needs its task word
            wrap_armed <= 1'b1;
            // back to start address for the read
            byte_adr <= byte_adr - xfer_len;
            range <= xfer_len;
          end
          state <= S_IDLE;
          irq_o <= (lvl != 6'h00);
        end
      end
    end
  end

  // =================================================================
  // memory request path, follows transfer state
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 24'h000000;
      mem_wdata_o <= 8'h00;
      busy_o <= 1'b0;
    end else begin
      busy_o <= !idle;
      // the request falls one cycle after the last ack; memory sees one
      // more request cycle and must not answer it within that cycle
      mem_req_o <= !idle && mp_busy && !do_init && !do_stop;
      mem_we_o <= (state != S_WRAPW);
      mem_addr_o <= {mod_adr, byte_adr};
      mem_wdata_o <= rdata;
    end
  end

  // =================================================================
  // input command answers, one cycle after request
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 16'h0000;
      rsp_addr_o <= 16'h0000;
    end else begin
      // data and echo are loaded on every cycle; only the valid pulse
      // marks an answer, which keeps the decode flat
      rsp_valid_o <= req_i && is_input(fc_i);
      rsp_addr_o <= data_i;
      case (fc_i)
        `DCC_FC_ID: rsp_data_o <= CTRL_ID;
        `DCC_FC_INTLVL: rsp_data_o <= {CHAN_NUM, lvl};
        `DCC_FC_MEMADR: rsp_data_o <= byte_adr;
        `DCC_FC_MODADR: rsp_data_o <= {8'h00, mod_adr};
        `DCC_FC_RANGE: rsp_data_o <= range;
        `DCC_FC_OFFS: rsp_data_o <= offs;
        `DCC_FC_CFGA: rsp_data_o <= cfg_a;
        `DCC_FC_CFGB: rsp_data_o <= cfg_b;
        `DCC_FC_CFGC: rsp_data_o <= cfg_c;
        `DCC_FC_STAT1: rsp_data_o <= stat1;
        `DCC_FC_TASK - 6'h01: rsp_data_o <= task_word;
        `DCC_FC_IDCODE: rsp_data_o <= unit_code_i;
        default: rsp_data_o <= 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- sim/dcc_cmd_port_checker.sv ----
// Purpose: timing relations at the channel command port
// Assumes: one clock, reset asynchronous and active low
// Notes: bound onto every dcc_cmd_port
`timescale 1ns/1ns
`default_nettype none
module dcc_cmd_port_checker #(
  parameter [15:0] CTRL_ID = 16'h0000,
  parameter [9:0] CHAN_NUM = 10'h000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request side
  input wire logic req_i,
  input wire logic [5:0] fc_i,
  input wire logic [15:0] data_i,
  input wire logic [15:0] unit_code_i,
  // answer and events
  input wire logic rsp_valid_o,
  input wire logic [15:0] rsp_data_o,
  input wire logic [15:0] rsp_addr_o,
  input wire logic irq_o,
  input wire logic recal_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==================================================================
  // request shapes
  sequence s_input;
    req_i && !fc_i[0];
  endsequence
  sequence s_init;
    req_i && fc_i == 6'h01 && data_i[0];
  endsequence
  sequence s_stop;
    req_i && fc_i == 6'h01 && data_i[1] && !data_i[0];
  endsequence
  // ==================================================================
  // answers, one cycle after the request
  a_rsp_next: assert property (s_input |=> rsp_valid_o)
    else $error("input command got no answer");
  a_out_silent: assert property (req_i && fc_i[0] |=> !rsp_valid_o)
    else $error("output command was answered");
  a_echo_addr: assert property (s_input |=> rsp_addr_o == $past(data_i))
    else $error("address echo differs from request data");
  a_ctrl_id: assert property (req_i && fc_i == 6'h00 |=> rsp_data_o == CTRL_ID)
    else $error("controller identifier wrong");
  a_unit_code: assert property (req_i && fc_i == 6'h26 |=>
    rsp_data_o == $past(unit_code_i))
    else $error("unit code wrong");
  a_chan_num: assert property (req_i && fc_i == 6'h02 |=>
    rsp_data_o[15:6] == CHAN_NUM)
    else $error("channel number wrong");
  // ==================================================================
  // control word effects
  a_init_recal: assert property (s_init |-> ##[1:2] recal_o)
    else $error("no recalibrate after initialize");
  a_init_quiet: assert property (s_init |=> (!irq_o)[*4])
    else $error("interrupt after initialize");
  a_init_idle: assert property (s_init |-> ##[1:4] !busy_o)
    else $error("still busy after initialize");
  a_stop_end: assert property (s_stop |-> ##[1:4] !busy_o)
    else $error("still busy after stop");
endmodule
bind dcc_cmd_port dcc_cmd_port_checker #(.CTRL_ID(CTRL_ID),
  .CHAN_NUM(CHAN_NUM)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .req_i(req_i), .fc_i(fc_i), .data_i(data_i), .unit_code_i(unit_code_i),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
  .rsp_addr_o(rsp_addr_o), .irq_o(irq_o), .recal_o(recal_o),
  .busy_o(busy_o));
`default_nettype wire

// ---- sim/dcc_mem_model.sv ----
// Purpose: main memory seen by the channel, byte wide
// Assumes: request held until acknowledged
// Notes: read byte is address xor 5a, garbage outside the ack
`timescale 1ns/1ns
`default_nettype none
module dcc_mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request from the channel
  input wire logic mem_req_i,
  input wire logic [23:0] mem_addr_i,
  input wire logic slow_i,
  // answer
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o
);
  int wait_n;
  // ack after one or four cycles; data inverts when not valid
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 8'h00;
      wait_n <= 0;
    end else if (mem_req_i && !mem_ack_o && wait_n < (slow_i ? 4 : 1)) begin
      wait_n <= wait_n + 1;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (mem_req_i && !mem_ack_o) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem_addr_i[7:0] ^ 8'h5a;
      wait_n <= 0;
    end else begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule
`default_nettype wire

// ---- sim/disk_channel_command_port_tb.sv ----
// Purpose: self-checking bench for the channel command port
// Assumes: inputs change on the falling edge
// Notes: answers checked by a monitor against a queue of notes
`timescale 1ns/1ns
`default_nettype none
`include "dcc_consts.vh"
module disk_channel_command_port_tb;
  localparam [15:0] CID = 16'h3c7e; // arbitrary value
  localparam [9:0] CHN = 10'h2a5;
  logic clk_i = 0, rst_n_i = 0, req_i = 0, master_clear_i = 0, slow = 0;
  logic [5:0] fc_i = 0;
  logic [15:0] data_i = 0, unit_code_i = 0, v;
  logic [47:0] r;
  logic [31:0] a;
  logic [47:0] rq[$];
  logic [31:0] aq[$];
  logic [5:0] oc[8] = '{6'h03, 6'h09, 6'h0b, 6'h0d, 6'h0f, 6'h11, 6'h13, 6'h15};
  logic [15:0] om[8] = '{16'h003f, 16'hffff, 16'h00ff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff};
  wire mem_ack_i, mem_req_o, mem_we_o, rsp_valid_o, irq_o, recal_o, busy_o;
  wire [7:0] mem_rdata_i, mem_wdata_o;
  wire [23:0] mem_addr_o;
  wire [15:0] rsp_data_o, rsp_addr_o;
  int n_fail = 0, tests_run = 0, nirq = 0, nrec = 0, nwr = 0, nack = 0;
  int i, k, j;
  dcc_cmd_port #(.CTRL_ID(CID), .CHAN_NUM(CHN)) dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .req_i(req_i), .fc_i(fc_i), .data_i(data_i),
    .master_clear_i(master_clear_i), .unit_code_i(unit_code_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_addr_o(rsp_addr_o), .irq_o(irq_o), .recal_o(recal_o),
    .busy_o(busy_o));
  dcc_mem_model u_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .slow_i(slow), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));
  // ==================================================================
  // clock, 10 ns
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [15:0] rnd();
    return 16'($urandom);
  endfunction
  // one request strobe; input codes leave a note {mask, value, echo}
  task automatic cyc(logic [5:0] f, logic [15:0] d, logic [15:0] e = 0,
    logic [15:0] m = 0);
    @(negedge clk_i);
    req_i = 1'b1;
    fc_i = f;
    data_i = d;
    if (!f[0]) rq.push_back({m, e, d});
    @(negedge clk_i);
    req_i = 1'b0;
  endtask
  // bounded wait for the channel to go idle
  task automatic wait_idle;
    int t;
    t = 0;
    repeat (2) @(negedge clk_i);
    while (busy_o !== 1'b0) begin
      @(negedge clk_i);
      t++;
      if (t > 5000) begin
        chk("busy timeout", 0, 1);
        test_done;
      end
    end
    repeat (3) @(negedge clk_i);
  endtask
  // ==================================================================
  // monitor: answers, memory traffic, event pulses
  // sampled at the falling edge, where every output stands settled
  always @(negedge clk_i) begin
    if (irq_o === 1'b1) nirq++;
    if (recal_o === 1'b1) nrec++;
    if (rsp_valid_o === 1'b1) begin
      r = rq.size() ? rq.pop_front() : 48'h0;
      chk("answer", r[31:16] & r[47:32], rsp_data_o & r[47:32]);
      chk("echo", r[15:0], rsp_addr_o);
    end
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
      nack++;
      if (mem_we_o === 1'b1) nwr++;
      if (aq.size()) begin
        a = aq.pop_front();
        chk("mem addr", a[31:8], mem_addr_o);
        if (mem_we_o === 1'b1) chk("mem byte", a[7:0], mem_wdata_o);
      end
    end
  end
  // ==================================================================
  // main sequence
  initial begin
    void'($urandom(31936));
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    unit_code_i = rnd();
    cyc(6'h00, rnd(), CID, 16'hffff);
    cyc(6'h02, rnd(), {CHN, 6'h00}, 16'hffff);
    cyc(6'h26, rnd(), unit_code_i, 16'hffff);
    for (i = 0; i < 8; i++) begin
      v = rnd();
      cyc(oc[i], v);
      cyc(oc[i] - 6'h01, rnd(), v, om[i]);
    end
    cyc(6'h03, 16'h0001);
    cyc(6'h09, 16'h0340);
    cyc(6'h0b, 16'h0007);
    cyc(6'h0d, 16'h0008);
    for (i = 0; i < 8; i++) aq.push_back({24'h070340 + 24'(i), 8'h00});
    k = nirq;
    cyc(6'h07, 16'h0001);
    wait_idle;
    chk("wrap write end irq", k + 1, nirq);
    for (i = 0; i < 8; i++)
      aq.push_back({24'h070340 + 24'(i), 8'(8'h40 + i) ^ 8'h5a});
    cyc(6'h07, 16'h0002);
    wait_idle;
    chk("wrap bytes left", 0, aq.size());
    k = nack;
    j = nirq;
    cyc(6'h0d, 16'h0000);
    cyc(6'h07, 16'h0001);
    wait_idle;
    chk("zero count traffic", k, nack);
    chk("zero count irq", j, nirq);
    cyc(6'h0d, 16'h0101);
    cyc(6'h07, 16'h0001);
    wait_idle;
    chk("oversize traffic", k, nack);
    cyc(6'h18, rnd(), 16'hffff, 16'h0001 << `DCC_PERR_BIT);
    master_clear_i = 1'b1;
    @(negedge clk_i);
    master_clear_i = 1'b0;
    cyc(6'h18, rnd(), 16'h0000, 16'h0001 << `DCC_PERR_BIT);
    cyc(6'h03, 16'h0001);
    cyc(6'h0d, 16'h0040);
    slow = 1'b1;
    k = nirq;
    cyc(6'h07, 16'h0001);
    repeat (6) @(negedge clk_i);
    cyc(6'h01, 16'h0002);
    wait_idle;
    chk("stop irq", k + 1, nirq);
    k = nirq;
    j = nrec;
    cyc(6'h07, 16'h0001);
    repeat (6) @(negedge clk_i);
    cyc(6'h01, 16'h0001);
    wait_idle;
    chk("init recal", j + 1, nrec);
    chk("init irq", k, nirq);
    cyc(6'h02, rnd(), {CHN, 6'h00}, 16'hffff);
    slow = 1'b0;
    k = nwr;
    cyc(6'h07, 16'h0003);
    wait_idle;
    chk("dump bytes", k + 256, nwr);
    chk("answers left", 0, rq.size());
    test_done;
  end
endmodule
`default_nettype wire
